/* File: rtl/atic_pkg.sv */
// constants, types and field layout of the aging trim / irq config mirror
// assumes a single 100 MHz clock domain with synchronous active-high reset
// Summary of operation
// - after power-up and first refresh delay, stored byte loads into the mirror
// - shipped value is 00h: both enables clear, trim zero
// - byte always readable; writes ignored while password protection active
// - bit7 power-up irq enable, bit6 low-voltage irq enable, bits5:0 trim
// - trim is six-bit two's complement, -32 to +31 steps
// - one trim step is 1/(32768*128), about 0.2384 ppm
// - enables gate each event onto the interrupt pin; clear means no assertion
package atic_pkg;

  localparam logic [7:0]  CFG_OFFSET        = 8'hC1;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  localparam int          PWR_IRQ_BIT       = 7;
  localparam int          LV_IRQ_BIT        = 6;
  localparam int          TRIM_MSB          = 5;
  localparam int          TRIM_W            = 6;
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          REFRESH_DELAY_MS  = 66;
  localparam int          REFRESH_CYCLES    = REFRESH_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          STEP_DENOM        = 32768 * 128;
  localparam int          STEP_PPB          = 238;

  typedef enum logic [1:0] {WAIT_REFRESH, LOAD, RUN} atic_phase_type;

  typedef struct packed {
    logic       pwrIrqEn;
    logic       lvIrqEn;
    logic [5:0] trim;
  } atic_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       wrEn;
    logic [7:0] wrData;
  } atic_req_type;

endpackage

/* File: rtl/atic_irq_gate.sv */
// interrupt request latch for one event source
// assumes event and flag-clear come from logic on the same clock
`timescale 1ns/1ps
module atic_irq_gate
  import atic_pkg::*;
(
  input  wire logic sys_clk,     // system clock
  input  wire logic rst,         // sync reset
  input  wire logic enable,      // enable bit from mirror
  input  wire logic eventPulse,  // event occurrence
  input  wire logic flagClear,   // software clears event flag
  output logic      irqReq       // held request
);

  typedef struct packed {
    logic req;
  } atic_gate_type;

  atic_gate_type st_ff;
  atic_gate_type nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (flagClear)
      nxt_st.req = 1'b0;
    // a new event wins over a simultaneous clear
    if (eventPulse && enable)
      nxt_st.req = 1'b1;
    if (!enable)
      nxt_st.req = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign irqReq = st_ff.req;

  held_until_clear_a : assert property (@(posedge sys_clk) disable iff (rst)
    (irqReq && enable && !flagClear) |=> irqReq) else $error("request dropped early");
  no_req_disabled_a : assert property (@(posedge sys_clk) disable iff (rst)
    !enable |=> !irqReq) else $error("request while disabled");
  event_sets_a : assert property (@(posedge sys_clk) disable iff (rst)
    (eventPulse && enable) |=> irqReq) else $error("event not latched");

endmodule

/* File: rtl/atic_mirror.sv */
// volatile mirror of the aging trim / irq enable configuration byte
// assumes stored byte, events and flag clears arrive on sys_clk; pins pre-synced
`timescale 1ns/1ps
module atic_mirror
  import atic_pkg::*;
#(
  parameter int REFRESH_CNT = REFRESH_CYCLES
)
(
  input  wire logic         sys_clk,        // system clock
  input  wire logic         rst,            // sync reset, power-up
  input  wire logic [7:0]   storedByte,     // nonvolatile stored value
  input  wire atic_req_type req,            // host register access
  input  wire logic         writeProtect,   // password protection active
  input  wire logic         pwrUpEvent,     // power-up event pulse
  input  wire logic         lowVoltEvent,   // low-voltage event pulse
  input  wire logic         pwrFlagClear,   // power_up_event_flag cleared
  input  wire logic         lvFlagClear,    // low-voltage flag cleared
  output logic [7:0]        rdData,         // read data
  output atic_cfg_type      mirror,         // mirror value to logic
  output logic signed [5:0] agingTrim,      // signed trim steps
  output logic              mirrorValid,    // first refresh done
  output logic              irqOut          // interrupt request
);

  initial
  begin
    if (REFRESH_CNT < 1)
      $error("REFRESH_CNT must be at least 1");
  end

  typedef struct packed {
    atic_phase_type phase;
    logic [31:0]    cnt;
    atic_cfg_type   cfg;
    logic [7:0]     rd;
  } atic_state_type;

  atic_state_type st_ff;
  atic_state_type nxt_st;
  logic           pwrReq;
  logic           lvReq;
  logic           hit;

  function automatic logic addrHit(input logic [7:0] a);
    addrHit = (a == CFG_OFFSET);
  endfunction

  assign hit = addrHit(req.addr);

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rd = hit ? st_ff.cfg : 8'h00;
    case (st_ff.phase)
      WAIT_REFRESH:
      begin
        if (st_ff.cnt >= 32'(REFRESH_CNT - 1))
          nxt_st.phase = LOAD;
        else
          nxt_st.cnt = st_ff.cnt + 32'h00000001;
      end
      LOAD:
      begin
        nxt_st.cfg = storedByte;
        nxt_st.phase = RUN;
      end
      RUN:
      begin
        // protected writes are dropped silently
        if (req.wrEn && hit && !writeProtect)
          nxt_st.cfg = req.wrData;
      end
      default:
        nxt_st.phase = WAIT_REFRESH;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_ff.phase <= WAIT_REFRESH;
      st_ff.cnt   <= 32'h00000000;
      st_ff.cfg   <= CFG_RESET;
      st_ff.rd    <= 8'h00;
    end
    else
      st_ff <= nxt_st;
  end

  //////////////////////////////////////////////////////////////////////////////

  atic_irq_gate u_pwr (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .enable     (st_ff.cfg.pwrIrqEn),
    .eventPulse (pwrUpEvent),
    .flagClear  (pwrFlagClear),
    .irqReq     (pwrReq)
  );

  atic_irq_gate u_lv (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .enable     (st_ff.cfg.lvIrqEn),
    .eventPulse (lowVoltEvent),
    .flagClear  (lvFlagClear),
    .irqReq     (lvReq)
  );

  assign irqOut      = pwrReq | lvReq;
  assign rdData      = st_ff.rd;
  assign mirror      = st_ff.cfg;
  // each step is 1/(32768*128) of frequency; consumer scales by STEP_DENOM
  assign agingTrim   = $signed(st_ff.cfg.trim);
  assign mirrorValid = (st_ff.phase == RUN);

  //////////////////////////////////////////////////////////////////////////////

  load_after_delay_a : assert property (@(posedge sys_clk) disable iff (rst)
    (st_ff.phase == LOAD) |=> (mirror == $past(storedByte) && mirrorValid))
    else $error("mirror not loaded from store");
  no_early_valid_a : assert property (@(posedge sys_clk) disable iff (rst)
    (st_ff.phase == WAIT_REFRESH) |-> !mirrorValid) else $error("valid too early");
  protect_blocks_a : assert property (@(posedge sys_clk) disable iff (rst)
    (mirrorValid && req.wrEn && writeProtect) |=> $stable(mirror))
    else $error("protected write took effect");
  write_lands_a : assert property (@(posedge sys_clk) disable iff (rst)
    (mirrorValid && req.wrEn && hit && !writeProtect) |=> mirror == $past(req.wrData))
    else $error("write lost");
  read_back_a : assert property (@(posedge sys_clk) disable iff (rst)
    hit |=> rdData == $past(mirror)) else $error("read data wrong");
  field_layout_a : assert property (@(posedge sys_clk) disable iff (rst)
    mirror.pwrIrqEn == rdData[PWR_IRQ_BIT] || !$past(hit) || $changed(mirror))
    else $error("enable bit misplaced");
  trim_sign_a : assert property (@(posedge sys_clk) disable iff (rst)
    (agingTrim < 0) == mirror.trim[TRIM_MSB]) else $error("trim sign wrong");
  irq_gate_a : assert property (@(posedge sys_clk) disable iff (rst)
    (!mirror.pwrIrqEn && !mirror.lvIrqEn) |=> !irqOut || $changed(mirror))
    else $error("irq while disabled");
  reset_value_a : assert property (@(posedge sys_clk)
    $past(rst) |-> mirror == CFG_RESET) else $error("reset value wrong");

endmodule

/* File: testbench/atic_host_model.sv */
// host side of the config byte: issues register reads and writes
// assumes calls start anywhere; requests change just after a rising edge
`timescale 1ns/1ps
module atic_host_model
  import atic_pkg::*;
(
  input  wire logic       sys_clk,  // system clock
  output atic_req_type    req,      // register request
  input  wire logic [7:0] rdData    // read data
);
  initial req = '0;
  // strobe lasts one edge; data inverted after release so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wrEn: 1'b1, wrData: d};
    @(posedge sys_clk);
    req <= '{addr: a, wrEn: 1'b0, wrData: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wrEn: 1'b0, wrData: 8'h00};
    @(posedge sys_clk);
    #1 d = rdData;
  endtask
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the config byte mirror
// assumes a short refresh count so the first load lands quickly
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  import atic_pkg::*;
  logic         sys_clk = 0;
  logic         rst = 1;
  logic [7:0]   storedByte = 8'h9F;
  logic         writeProtect = 0;
  logic         pwrUpEvent = 0;
  logic         lowVoltEvent = 0;
  logic         pwrFlagClear = 0;
  logic         lvFlagClear = 0;
  atic_req_type req;
  logic [7:0]   rdData;
  atic_cfg_type mirror;
  logic signed [5:0] agingTrim;
  logic         mirrorValid;
  logic         irqOut;
  logic [7:0]   d;
  int           error_cnt = 0;
  int           cmp_count = 0;
  atic_mirror #(.REFRESH_CNT(8)) i_atic_mirror (.sys_clk(sys_clk), .rst(rst),
    .storedByte(storedByte), .req(req), .writeProtect(writeProtect),
    .pwrUpEvent(pwrUpEvent), .lowVoltEvent(lowVoltEvent), .pwrFlagClear(pwrFlagClear),
    .lvFlagClear(lvFlagClear), .rdData(rdData), .mirror(mirror), .agingTrim(agingTrim),
    .mirrorValid(mirrorValid), .irqOut(irqOut));
  atic_host_model i_atic_host_model (.sys_clk(sys_clk), .req(req), .rdData(rdData));
  initial forever #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one-cycle pulse on event or flag-clear k, irq sampled once it has landed
  task automatic pulse(input int k);
    @(posedge sys_clk);
    {pwrUpEvent, lowVoltEvent, pwrFlagClear, lvFlagClear} <= 4'h8 >> k;
    @(posedge sys_clk);
    {pwrUpEvent, lowVoltEvent, pwrFlagClear, lvFlagClear} <= 4'h0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("mirror", 8'h00, mirror)
    `CHK("irq", 1'b0, irqOut)
    @(posedge sys_clk);
    rst <= 0;
    i_atic_host_model.wr(8'hC1, 8'hFF);
    #1 `CHK("early wr", 8'h00, mirror)
  endtask
  task automatic t_load;
    for (int i = 0; i < 30 && mirrorValid !== 1'b1; i++)
      @(posedge sys_clk);
    #1 `CHK("loaded", 8'h9F, mirror)
    `CHK("trim max", 6'h1F, agingTrim)
    `CHK("pwr en", 1'b1, mirror.pwrIrqEn)
  endtask
  task automatic t_protect;
    writeProtect <= 1;
    i_atic_host_model.wr(8'hC1, 8'h00);
    i_atic_host_model.rd(8'hC1, d);
    `CHK("protected", 8'h9F, d)
    i_atic_host_model.rd(8'hC2, d);
    `CHK("unmapped", 8'h00, d)
    writeProtect <= 0;
  endtask
  task automatic t_irq;
    i_atic_host_model.wr(8'hC1, 8'h60);
    #1 `CHK("lv en", 2'b01, {mirror.pwrIrqEn, mirror.lvIrqEn})
    `CHK("trim min", 6'h20, agingTrim)
    pulse(0);
    `CHK("masked", 1'b0, irqOut)
    pulse(1);
    `CHK("raised", 1'b1, irqOut)
    repeat (3) @(posedge sys_clk);
    #1 `CHK("held", 1'b1, irqOut)
    pulse(3);
    `CHK("cleared", 1'b0, irqOut)
  endtask
  // power-up path, event against clear in one cycle, then a mid-run reset and reload
  task automatic t_pwr;
    i_atic_host_model.wr(8'hC1, 8'h80);
    pulse(0);
    `CHK("pwr raised", 1'b1, irqOut)
    pulse(2);
    `CHK("pwr cleared", 1'b0, irqOut)
    @(posedge sys_clk);
    {pwrUpEvent, pwrFlagClear} <= 2'b11;
    @(posedge sys_clk);
    {pwrUpEvent, pwrFlagClear} <= 2'b00;
    #1 `CHK("event wins", 1'b1, irqOut)
    @(posedge sys_clk);
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("rst mirror", 8'h00, mirror)
    `CHK("rst irq", 1'b0, irqOut)
    `CHK("rst valid", 1'b0, mirrorValid)
    @(posedge sys_clk);
    rst <= 0;
    repeat (8) @(posedge sys_clk);
    #1 `CHK("not yet valid", 1'b0, mirrorValid)
    @(posedge sys_clk);
    #1 `CHK("reloaded", 8'h9F, mirror)
    `CHK("valid", 1'b1, mirrorValid)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge sys_clk);
    t_reset();
    t_load();
    t_protect();
    t_irq();
    t_pwr();
    end_sim();
  end
  // whole run is under 100 cycles; a hang is cut off well past that
  initial
  begin
    #20000;
    error_cnt++;
    end_sim();
  end
endmodule
